// File: verilog/pcs_tx_pkg.sv
// Shared constants and carriers for the transmit code-group mapper.
// Assumes a single transmit parallel clock; no software registers.
package pcs_tx_pkg;

    // ------------------------------------------------------------
    // Character bytes (XGMII and 8b/10b special bytes)
    // ------------------------------------------------------------
    localparam logic [7:0] K28_0_BYTE  = 8'h1c;
    localparam logic [7:0] K28_3_BYTE  = 8'h7c;
    localparam logic [7:0] K28_5_BYTE  = 8'hbc;
    localparam logic [7:0] XGMII_IDLE  = 8'h07;
    localparam logic [7:0] XGMII_SEQ   = 8'h9c;
    localparam logic [7:0] XGMII_START = 8'hfb;
    localparam logic [7:0] XGMII_TERM  = 8'hfd;
    localparam logic [7:0] ERROR_BYTE  = 8'hfe;

    // ------------------------------------------------------------
    // Timing counts and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] COMMA_COUNT   = 2'h3;
    localparam logic [3:0] ALIGN_PERIOD  = 4'h0;
    localparam logic [9:0] CODE_RESET    = 10'h000;
    localparam logic       RD_RESET      = 1'b0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       ctl;
        logic [7:0] dat;
    } xgmii_char_t;

    typedef struct packed {
        logic [9:0] code;
        logic       rd;
    } line_sym_t;

endpackage : pcs_tx_pkg

// File: verilog/code_group_encoder.sv
// Combinational 8b/10b encoder for one byte.
// Caller holds running disparity; code bit 9 is line bit a (sent first).
`timescale 1ns/1ns
module code_group_encoder
    import pcs_tx_pkg::*;
(
    // Byte in
    input  wire logic [7:0] byte_in,
    input  wire logic       k_in,
    input  wire logic       rd_in,
    // Code group out
    output line_sym_t       sym_out
);

    // ------------------------------------------------------------
    // Negative-disparity tables
    // ------------------------------------------------------------
    function automatic logic [5:0] sixb_neg(input logic [4:0] x);
        logic [5:0] t;
        t = 6'h00;
        case (x)
            5'd0:    t = 6'b100111;
            5'd1:    t = 6'b011101;
            5'd2:    t = 6'b101101;
            5'd3:    t = 6'b110001;
            5'd4:    t = 6'b110101;
            5'd5:    t = 6'b101001;
            5'd6:    t = 6'b011001;
            5'd7:    t = 6'b111000;
            5'd8:    t = 6'b111001;
            5'd9:    t = 6'b100101;
            5'd10:   t = 6'b010101;
            5'd11:   t = 6'b110100;
            5'd12:   t = 6'b001101;
            5'd13:   t = 6'b101100;
            5'd14:   t = 6'b011100;
            5'd15:   t = 6'b010111;
            5'd16:   t = 6'b011011;
            5'd17:   t = 6'b100011;
            5'd18:   t = 6'b010011;
            5'd19:   t = 6'b110010;
            5'd20:   t = 6'b001011;
            5'd21:   t = 6'b101010;
            5'd22:   t = 6'b011010;
            5'd23:   t = 6'b111010;
            5'd24:   t = 6'b110011;
            5'd25:   t = 6'b100110;
            5'd26:   t = 6'b010110;
            5'd27:   t = 6'b110110;
            5'd28:   t = 6'b001110;
            5'd29:   t = 6'b101110;
            5'd30:   t = 6'b011110;
            default: t = 6'b101011;
        endcase
        return t;
    endfunction : sixb_neg

    function automatic logic [3:0] fourb_neg(input logic [2:0] y, input logic alt);
        logic [3:0] t;
        t = 4'h0;
        case (y)
            3'd0: t = 4'b1011;
            3'd1: t = 4'b1001;
            3'd2: t = 4'b0101;
            3'd3: t = 4'b1100;
            3'd4: t = 4'b1101;
            3'd5: t = 4'b1010;
            3'd6: t = 4'b0110;
            default: t = alt ? 4'b0111 : 4'b1110;
        endcase
        return t;
    endfunction : fourb_neg

    // ------------------------------------------------------------
    // Disparity selection
    // ------------------------------------------------------------
    logic [4:0] x;
    logic [2:0] y;
    logic       k28;
    logic [5:0] six;
    logic [3:0] four;
    logic       rd_mid;
    logic       alt7;

    always_comb begin
        x      = byte_in[4:0];
        y      = byte_in[7:5];
        k28    = k_in && (x == 5'd28);
        six    = k28 ? 6'b001111 : sixb_neg(x);
        // D.7 is balanced yet still alternates with disparity
        if (rd_in && (($countones(six) != 3) || (!k28 && x == 5'd7))) begin
            six = ~six;
        end
        rd_mid = rd_in ^ ($countones(six) != 3);
        // Alternate x.7 avoids a run of five across the i/f sub-block boundary
        alt7   = k_in || (!rd_mid && (x == 5'd17 || x == 5'd18 || x == 5'd20))
                      || (rd_mid && (x == 5'd11 || x == 5'd13 || x == 5'd14));
        four   = fourb_neg(y, alt7);
        if (rd_mid && (($countones(four) != 2) || y == 3'd3)) begin
            four = ~four;
        end else if (k28 && !rd_mid && ($countones(four) == 2) && y != 3'd3) begin
            four = ~four;
        end
        sym_out.code = {six, four};
        sym_out.rd   = rd_mid ^ ($countones(four) != 2);
    end

endmodule : code_group_encoder

// File: verilog/pcs_tx_code_group_mapper.sv
// Transmit code-group mapper: start-up commas and XGMII to 10-bit mapping.
// Assumes fabric logic on sys_clk drives the character stream directly.
//
// Contract
// - Gigabit mode: three K28.5 after reset release
// - XAUI data bytes encode as data groups
// - Idle in I context becomes K28.0/3/5
// - Idle in T context becomes K28.5
// - 9C, FB, FD map to K28.4, K27.7, K29.7
`timescale 1ns/1ns
module pcs_tx_code_group_mapper
    import pcs_tx_pkg::*;
(
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // Mode
    input  wire logic         gigabit_ethernet_mode,
    // Character stream from fabric
    input  wire xgmii_char_t  char_in,
    input  wire logic         char_valid,
    output logic              char_ready_r,
    // Serial-side code group
    output logic [9:0]        code_r,
    output logic              rd_r
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_COMMA,
        ST_RUN
    } tx_state_t;

    tx_state_t  state_r;
    tx_state_t  state_nxt;
    logic [1:0] comma_cnt_r;
    logic [1:0] comma_cnt_nxt;
    logic       ready_nxt;
    logic       after_term_r;
    logic       after_term_nxt;
    logic [3:0] idle_cnt_r;
    logic [3:0] idle_cnt_nxt;
    logic [9:0] code_nxt;
    logic       rd_nxt;

    logic       take;
    logic [7:0] enc_byte;
    logic       enc_k;
    line_sym_t  enc_sym;

    // ------------------------------------------------------------
    // Idle selection in I context
    // ------------------------------------------------------------
    // Periodic K28.3 lets the far end align lanes; others alternate
    function automatic logic [7:0] idle_pick(input logic [3:0] cnt);
        logic [7:0] b;
        b = K28_5_BYTE;
        if (cnt == ALIGN_PERIOD) begin
            b = K28_3_BYTE;
        end else if (cnt[0]) begin
            b = K28_0_BYTE;
        end
        return b;
    endfunction : idle_pick

    assign take = char_ready_r && char_valid;

    // ------------------------------------------------------------
    // Next-state and character selection
    // ------------------------------------------------------------
    always_comb begin
        state_nxt      = state_r;
        comma_cnt_nxt  = comma_cnt_r;
        ready_nxt      = char_ready_r;
        after_term_nxt = after_term_r;
        idle_cnt_nxt   = idle_cnt_r + 4'h1;
        enc_byte       = K28_5_BYTE;
        enc_k          = 1'b1;
        case (state_r)
            ST_COMMA: begin
                enc_byte = K28_5_BYTE;
                enc_k    = 1'b1;
                if (!gigabit_ethernet_mode) begin
                    state_nxt = ST_RUN;
                    ready_nxt = 1'b1;
                end else begin
                    comma_cnt_nxt = comma_cnt_r + 2'h1;
                    // User data held off until the last comma is out
                    if (comma_cnt_r == COMMA_COUNT - 2'h1) begin
                        state_nxt = ST_RUN;
                        ready_nxt = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (!take) begin
                    // No character offered: keep the line in idle
                    enc_byte = gigabit_ethernet_mode ? K28_5_BYTE : idle_pick(idle_cnt_r);
                    enc_k    = 1'b1;
                end else if (gigabit_ethernet_mode) begin
                    enc_byte = char_in.dat;
                    enc_k    = char_in.ctl;
                end else if (!char_in.ctl) begin
                    enc_byte       = char_in.dat;
                    enc_k          = 1'b0;
                    after_term_nxt = 1'b0;
                end else begin
                    enc_k          = 1'b1;
                    after_term_nxt = (char_in.dat == XGMII_TERM);
                    case (char_in.dat)
                        XGMII_IDLE: begin
                            if (after_term_r) begin
                                enc_byte = K28_5_BYTE;
                            end else begin
                                enc_byte = idle_pick(idle_cnt_r);
                            end
                        end
                        // Control bytes share their value with the K code
                        XGMII_SEQ:   enc_byte = XGMII_SEQ;
                        XGMII_START: enc_byte = XGMII_START;
                        XGMII_TERM:  enc_byte = XGMII_TERM;
                        default:     enc_byte = ERROR_BYTE;
                    endcase
                end
            end
            default: begin
                state_nxt = ST_COMMA;
                ready_nxt = 1'b0;
            end
        endcase
        code_nxt = enc_sym.code;
        rd_nxt   = enc_sym.rd;
    end

    code_group_encoder u_enc (
        .byte_in (enc_byte),
        .k_in    (enc_k),
        .rd_in   (rd_r),
        .sym_out (enc_sym)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_r      <= ST_COMMA;
            comma_cnt_r  <= 2'h0;
            char_ready_r <= 1'b0;
            after_term_r <= 1'b0;
            idle_cnt_r   <= 4'h0;
            code_r       <= CODE_RESET;
            rd_r         <= RD_RESET;
        end else begin
            state_r      <= state_nxt;
            comma_cnt_r  <= comma_cnt_nxt;
            char_ready_r <= ready_nxt;
            after_term_r <= after_term_nxt;
            idle_cnt_r   <= idle_cnt_nxt;
            code_r       <= code_nxt;
            rd_r         <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_comma_first;
        @(posedge sys_clk) disable iff (!rst_b)
        ($rose(rst_b) && gigabit_ethernet_mode)
            |=> ((code_r inside {10'h0fa, 10'h305}) && !char_ready_r) [*2]
                ##1 ((code_r inside {10'h0fa, 10'h305}) && char_ready_r);
    endproperty
    a_comma_first: assert property (p_comma_first)
        else $error("start-up comma sequence wrong");

    property p_data_map;
        @(posedge sys_clk) disable iff (!rst_b)
        (take && !gigabit_ethernet_mode && !char_in.ctl && char_in.dat == 8'h00)
            |=> (code_r inside {10'h274, 10'h18b});
    endproperty
    a_data_map: assert property (p_data_map)
        else $error("data byte not mapped to data group");

    property p_idle_i;
        @(posedge sys_clk) disable iff (!rst_b)
        (take && !gigabit_ethernet_mode && char_in.ctl && char_in.dat == XGMII_IDLE
            && !after_term_r)
            |=> ((code_r[9:4] inside {6'b001111, 6'b110000})
                && (code_r[3:0] inside {4'h4, 4'hb, 4'h3, 4'hc, 4'ha, 4'h5}));
    endproperty
    a_idle_i: assert property (p_idle_i)
        else $error("idle in I context badly coded");

    property p_idle_t;
        @(posedge sys_clk) disable iff (!rst_b)
        (take && !gigabit_ethernet_mode && char_in.ctl && char_in.dat == XGMII_TERM)
            ##1 (take && char_in.ctl && char_in.dat == XGMII_IDLE)
            |=> (code_r inside {10'h0fa, 10'h305});
    endproperty
    a_idle_t: assert property (p_idle_t)
        else $error("idle after terminate not K28.5");

    property p_ctrl_map;
        @(posedge sys_clk) disable iff (!rst_b)
        (take && !gigabit_ethernet_mode && char_in.ctl)
            |=> ($past(char_in.dat) == XGMII_SEQ   -> code_r inside {10'h0f2, 10'h30d})
             && ($past(char_in.dat) == XGMII_START -> code_r inside {10'h368, 10'h097})
             && ($past(char_in.dat) == XGMII_TERM  -> code_r inside {10'h2e8, 10'h117});
    endproperty
    a_ctrl_map: assert property (p_ctrl_map)
        else $error("control character mapped wrongly");

    property p_disparity;
        @(posedge sys_clk) disable iff (!rst_b)
        $past(rst_b) |-> (($countones(code_r) inside {4, 5, 6})
            && (rd_r == ($past(rd_r) ^ ($countones(code_r) != 5)))
            && ($countones(code_r) == 5 || rd_r == ($countones(code_r) == 6)));
    endproperty
    a_disparity: assert property (p_disparity)
        else $error("running disparity broken");

endmodule : pcs_tx_code_group_mapper

// File: tb/line_rx_model.sv
// Remote line receiver model: follows running disparity of the line.
// Assumes one code group per rising sys_clk edge, bit 9 sent first.
`timescale 1ns/1ns
module line_rx_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // Line side
    input  wire logic [9:0] code_r,
    input  wire logic       rd_r,
    // Status
    output logic            rd_track_r,
    output logic            disp_err_r
);
    logic       run_r;
    logic       rd_nxt;
    logic       err_nxt;
    logic [3:0] ones;

    // ----------------------------------------------
    // Disparity tracking
    // ----------------------------------------------
    always_comb begin
        ones = 4'($countones(code_r));
        rd_nxt = rd_track_r ^ (ones != 4'h5);
        err_nxt = (ones < 4'h4) || (ones > 4'h6) || (ones == 4'h6 && rd_track_r)
            || (ones == 4'h4 && !rd_track_r) || (rd_r != rd_nxt);
    end

    // Reset code of zeros is not a group, so tracking starts one edge late
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            run_r      <= 1'b0;
            rd_track_r <= 1'b0;
            disp_err_r <= 1'b0;
        end else begin
            run_r      <= 1'b1;
            rd_track_r <= run_r ? rd_nxt : rd_track_r;
            disp_err_r <= run_r & err_nxt;
        end
    end
endmodule : line_rx_model

// File: tb/test_pcs_tx_code_group_mapper.sv
// Self-checking bench for the transmit code-group mapper.
// Assumes the line model tracks disparity; stimulus changes on falling edges.
`timescale 1ns/1ns
`define CHECK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_pcs_tx_code_group_mapper
    import pcs_tx_pkg::*;
;
    typedef struct packed {
        logic [1:0] kind;
        logic       k;
        logic [7:0] b;
        logic       rdy;
    } note_t;

    localparam logic [5:0] SIX_B [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19,
        6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13,
        6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] FOUR_B [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

    logic        sys_clk;
    logic        rst_b;
    logic        gigabit_ethernet_mode;
    xgmii_char_t char_in;
    logic        char_valid;
    logic        char_ready_r;
    logic [9:0]  code_r;
    logic        rd_r;
    logic        rd_track_r;
    logic        disp_err_r;
    logic [31:0] lfsr_r;
    logic        t_ctx;
    logic [9:0]  exp_code;
    note_t       n;
    note_t       got;
    note_t       q[$];
    int          n_mismatch;
    int          num_checks;
    int          i;

    pcs_tx_code_group_mapper DUT (.sys_clk(sys_clk), .rst_b(rst_b),
        .gigabit_ethernet_mode(gigabit_ethernet_mode), .char_in(char_in),
        .char_valid(char_valid), .char_ready_r(char_ready_r), .code_r(code_r), .rd_r(rd_r));
    line_rx_model rx_model (.sys_clk(sys_clk), .rst_b(rst_b), .code_r(code_r), .rd_r(rd_r),
        .rd_track_r(rd_track_r), .disp_err_r(disp_err_r));

    always #50 sys_clk = ~sys_clk;

    // ----------------------------------------------
    // Reference encoder and stimulus helpers
    // ----------------------------------------------
    function automatic logic [9:0] enc(input logic k, input logic [7:0] b, input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic       rd1;
        logic       alt;
        if (k) begin
            case (b)
                K28_0_BYTE:  return rd ? 10'h30b : 10'h0f4;
                K28_3_BYTE:  return rd ? 10'h30c : 10'h0f3;
                XGMII_SEQ:   return rd ? 10'h30d : 10'h0f2;
                XGMII_START: return rd ? 10'h097 : 10'h368;
                XGMII_TERM:  return rd ? 10'h117 : 10'h2e8;
                ERROR_BYTE:  return rd ? 10'h217 : 10'h1e8;
                default:     return rd ? 10'h305 : 10'h0fa;
            endcase
        end
        s6 = SIX_B[b[4:0]];
        if (rd && ($countones(s6) != 3 || b[4:0] == 5'h07)) s6 = ~s6;
        rd1 = rd ^ ($countones(s6) != 3);
        alt = rd1 ? (b[4:0] inside {5'h0b, 5'h0d, 5'h0e}) : (b[4:0] inside {5'h11, 5'h12, 5'h14});
        s4 = (b[7:5] == 3'h7) ? (alt ? 4'h7 : 4'he) : FOUR_B[b[7:5]];
        if (rd1 && ($countones(s4) != 2 || b[7:5] == 3'h3 || b[7:5] == 3'h7)) s4 = ~s4;
        return {s6, s4};
    endfunction : enc

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic send(input logic v, input logic k, input logic [7:0] b);
        @(negedge sys_clk);
        char_valid = v;
        char_in = {k, b};
        n = '{kind: 2'h0, k: k, b: b, rdy: 1'b1};
        if (!v) n = '{kind: {1'b0, !gigabit_ethernet_mode}, k: 1'b1, b: K28_5_BYTE, rdy: 1'b1};
        else if (!gigabit_ethernet_mode && k && b == XGMII_IDLE) begin
            if (t_ctx) n.b = K28_5_BYTE;
            else n.kind = 2'h1;
        end
        else if (!gigabit_ethernet_mode && k
            && !(b inside {XGMII_SEQ, XGMII_START, XGMII_TERM})) n.b = ERROR_BYTE;
        if (v) t_ctx = k && b == XGMII_TERM;
        q.push_back(n);
    endtask : send

    task automatic restart(input logic mode);
        for (int c = 0; c < 5; c++) begin
            @(negedge sys_clk);
            rst_b = 1'b0;
            gigabit_ethernet_mode = mode;
            char_valid = 1'b0;
            q.push_back('{kind: 2'h2, k: 1'b0, b: 8'h00, rdy: 1'b0});
        end
        t_ctx = 1'b0;
        // Offer data during gigabit start-up: it must be refused
        for (int c = 0; c < (mode ? 3 : 1); c++) begin
            @(negedge sys_clk);
            rst_b = 1'b1;
            char_valid = mode;
            char_in = {1'b0, 8'h55};
            q.push_back('{kind: 2'h0, k: 1'b1, b: K28_5_BYTE, rdy: !mode || c == 2});
        end
    endtask : restart

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // ----------------------------------------------
    // Output watcher
    // ----------------------------------------------
    always @(posedge sys_clk) begin
        #1;
        if (q.size() > 0) begin
            got = q.pop_front();
            exp_code = (got.kind == 2'h2) ? 10'h000 : enc(got.k, got.b, rd_track_r);
            if (got.kind == 2'h1 && (code_r === enc(1'b1, K28_0_BYTE, rd_track_r)
                || code_r === enc(1'b1, K28_3_BYTE, rd_track_r))) exp_code = code_r;
            `CHECK(code_r, exp_code)
            `CHECK(char_ready_r, got.rdy)
            `CHECK(disp_err_r, 1'b0)
        end
    end

    // ----------------------------------------------
    // Main sequence
    // ----------------------------------------------
    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        gigabit_ethernet_mode = 1'b1;
        char_in = '0;
        char_valid = 1'b0;
        lfsr_r = 32'h72a8;
        n_mismatch = 0;
        num_checks = 0;
        restart(1'b1);
        // One data group keeps the sequence comma on an even boundary
        send(1'b1, 1'b0, 8'h4a);
        send(1'b1, 1'b1, K28_5_BYTE);
        for (i = 0; i < 24; i++) begin
            lfsr_r = lfsr(lfsr_r);
            send(1'b1, 1'b0, lfsr_r[7:0]);
        end
        send(1'b0, 1'b0, 8'h00);
        $display("test gigabit start done");
        restart(1'b0);
        for (i = 0; i < 256; i++) send(1'b1, 1'b0, 8'(i));
        foreach (FOUR_B[j]) send(1'b1, 1'b1, j[0] ? XGMII_SEQ : XGMII_START);
        // Unknown control bytes go out as the error group
        send(1'b1, 1'b1, 8'h5a);
        send(1'b1, 1'b1, 8'h3c);
        for (i = 0; i < 40; i++) begin
            lfsr_r = lfsr(lfsr_r);
            send(1'b1, 1'b0, lfsr_r[7:0]);
            if (lfsr_r[9:8] == 2'h0) send(1'b1, 1'b1, XGMII_TERM);
            if (lfsr_r[10]) send(1'b1, 1'b1, XGMII_IDLE);
        end
        for (i = 0; i < 20; i++) send(1'b1, 1'b1, XGMII_IDLE);
        send(1'b0, 1'b0, 8'h00);
        send(1'b1, 1'b1, XGMII_TERM);
        send(1'b1, 1'b1, XGMII_IDLE);
        send(1'b0, 1'b0, 8'h00);
        $display("test xaui mapping done");
        for (i = 0; i < 10 && q.size() > 0; i++) @(posedge sys_clk);
        if (q.size() > 0) n_mismatch++;
        // Last group's disparity verdict lands one edge after it
        #1;
        `CHECK(disp_err_r, 1'b0)
        finish_test();
    end
endmodule : test_pcs_tx_code_group_mapper
